//--- src/canes_pkg.sv
package canes_pkg;
  // Register map and field positions
  localparam logic [7:0] CANES_GIT_ADDR = 8'h9B;
  localparam logic [7:0] CANES_TEC_ADDR = 8'h9C;
  localparam logic [7:0] CANES_REC_ADDR = 8'h9D;
  localparam int CANES_BIT_SUMMARY = 7;
  localparam int CANES_BIT_RSVD = 6;
  localparam int CANES_BIT_TIMER = 5;
  localparam int CANES_BIT_BUF = 4;
  localparam int CANES_BIT_STUFF = 3;
  localparam int CANES_BIT_CRC = 2;
  localparam int CANES_BIT_FORM = 1;
  localparam int CANES_BIT_ACK = 0;
  localparam logic [7:0] CANES_GIT_RESET = 8'h00;
  localparam logic [7:0] CANES_CNT_RESET = 8'h00;
  localparam logic [15:0] CANES_TIMER_RESET = 16'h0000;
  localparam logic [15:0] CANES_TIMER_MAX = 16'hFFFF;
  // Bit stream checking
  localparam logic [2:0] CANES_STUFF_RUN = 3'h5;
  localparam logic [14:0] CANES_CRC_POLY = 15'h4599;
  localparam logic [14:0] CANES_CRC_RESET = 15'h0000;
  // Fault confinement steps
  localparam logic [7:0] CANES_TX_ERR_STEP = 8'h08;
  localparam logic [7:0] CANES_RX_ERR_STEP = 8'h01;
  localparam logic [7:0] CANES_CNT_MAX = 8'hFF;
  localparam logic [7:0] CANES_REC_PASSIVE_TOP = 8'h7F;

  typedef enum logic [6:0] {
    CANES_FLD_OTHER = 7'h01,
    CANES_FLD_FRAME = 7'h02,
    CANES_FLD_CRC = 7'h04,
    CANES_FLD_CRC_DELIM = 7'h08,
    CANES_FLD_ACK_SLOT = 7'h10,
    CANES_FLD_ACK_DELIM = 7'h20,
    CANES_FLD_EOF = 7'h40
  } canes_field_type;

  typedef struct packed {
    logic stuffErr;
    logic crcErr;
    logic formErr;
    logic ackErr;
  } canes_err_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic [7:0] wrData;
  } canes_sfr_req_type;
endpackage

//--- src/canes_error_status.sv
`timescale 1ns/1ps
// What this block does
// - Bit 7 mirrors every controller interrupt request
// - Timer wrap FFFF to 0000 sets bit 5
// - Timer flag with enable raises interrupt
// - Buffer full sets sticky bit 4
// - Sixth equal consecutive bit sets bit 3
// - Error flags interrupt-capable, sticky until cleared
// - CRC over destuffed SOF through data
// - CRC mismatch sets bit 2
// - Fixed-form violations set bit 1
// - Recessive acknowledge slot sets bit 0
// - Defined bits reset to zero
// - Read-only transmit error counter, reset zero
// - Read-only receive error counter, reset zero
// - General error interrupt gated by its enable
// - Buffer interrupt gated by its enable
module canes_error_status (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // SFR access
  input canes_pkg::canes_sfr_req_type sfrReq,
  output logic [7:0] sfrRdData,
  // Interrupt enables held elsewhere, plus another interrupt request
  input wire logic timerWrapIrqEnable,
  input wire logic generalErrorIrqEnable,
  input wire logic bufferIrqEnable,
  input wire logic otherIrq,
  // Controller events
  input wire logic timerTick,
  input wire logic rxBufferFull,
  input wire logic isTransmitter,
  input wire logic txFrameOk,
  input wire logic rxFrameOk,
  // Sampled bus bits
  input wire logic bitValid,
  input wire logic rxBit,
  input wire logic frameStart,
  input canes_pkg::canes_field_type frameField,
  output logic destuffedValid,
  // Interrupt request and counters
  output logic controllerIrq,
  output logic [15:0] canTimer,
  output logic [7:0] txErrorCount,
  output logic [7:0] rxErrorCount
);
  import canes_pkg::*;

  logic [5:0] flags_q, flags_d;
  logic [15:0] timer_q, timer_d;
  logic [7:0] tec_q, tec_d, rec_q, rec_d;
  logic [2:0] runLen_q, runLen_d;
  logic lastBit_q, lastBit_d;
  logic [14:0] crc_q, crc_d, rxCrc_q, rxCrc_d;
  logic [7:0] rdData_q, rdData_d;
  canes_err_type err;
  logic stuffHit, crcHit, formHit, ackHit;
  logic timerWrap, gitWrite, stuffed, stuffBit, useBit;
  logic timerIrq, bufIrq, generalIrq;

  function automatic logic [14:0] crcStep(input logic [14:0] crc, input logic b);
    logic [14:0] sh;
    sh = {crc[13:0], 1'b0};
    crcStep = (b ^ crc[14]) ? (sh ^ CANES_CRC_POLY) : sh;
  endfunction

  function automatic logic [7:0] satAdd(input logic [7:0] v, input logic [7:0] s);
    logic [8:0] sum;
    sum = {1'b0, v} + {1'b0, s};
    satAdd = sum[8] ? CANES_CNT_MAX : sum[7:0];
  endfunction

  assign stuffed = (frameField == CANES_FLD_FRAME) || (frameField == CANES_FLD_CRC);
  assign gitWrite = sfrReq.wrEn && (sfrReq.addr == CANES_GIT_ADDR);

  // Destuffing and stuff check
  always_comb begin
    logic [2:0] base;
    logic lb;
    base = frameStart ? 3'h0 : runLen_q;
    lb = frameStart ? ~rxBit : lastBit_q;
    runLen_d = runLen_q;
    lastBit_d = lastBit_q;
    stuffBit = 1'b0;
    stuffHit = 1'b0;
    if (bitValid && stuffed) begin
      if (base == CANES_STUFF_RUN) begin
        stuffBit = 1'b1;
        stuffHit = (rxBit == lb);
        runLen_d = 3'h1;
      end else if (rxBit == lb) begin
        runLen_d = base + 3'h1;
      end else begin
        runLen_d = 3'h1;
      end
      lastBit_d = rxBit;
    end
  end
  assign useBit = bitValid && stuffed && !stuffBit;
  assign destuffedValid = useBit;
  // One driver for the whole error vector
  assign err = {stuffHit, crcHit, formHit, ackHit};

  // CRC computation and frame checks
  always_comb begin
    logic [14:0] cb;
    cb = frameStart ? CANES_CRC_RESET : crc_q;
    crc_d = frameStart ? CANES_CRC_RESET : crc_q;
    rxCrc_d = rxCrc_q;
    crcHit = 1'b0;
    formHit = 1'b0;
    ackHit = 1'b0;
    if (useBit && frameField == CANES_FLD_FRAME) begin
      crc_d = crcStep(cb, rxBit);
    end
    if (useBit && frameField == CANES_FLD_CRC) begin
      rxCrc_d = {rxCrc_q[13:0], rxBit};
    end
    if (bitValid) begin
      case (frameField)
        CANES_FLD_CRC_DELIM: begin
          crcHit = (rxCrc_q != crc_q);
          formHit = !rxBit;
        end
        CANES_FLD_ACK_SLOT: ackHit = rxBit;
        CANES_FLD_ACK_DELIM: formHit = !rxBit;
        CANES_FLD_EOF: formHit = !rxBit;
        default: ;
      endcase
    end
  end

  // Timer and flags
  always_comb begin
    logic [5:0] setV, clrV;
    timer_d = timerTick ? timer_q + 16'h0001 : timer_q;
    timerWrap = timerTick && (timer_q == CANES_TIMER_MAX);
    setV = {timerWrap, rxBufferFull, err.stuffErr, err.crcErr, err.formErr, err.ackErr};
    clrV = gitWrite ? ~sfrReq.wrData[5:0] : 6'h00;
    // Set after clear so a coinciding event survives
    flags_d = (flags_q & ~clrV) | setV;
  end

  assign timerIrq = timerWrapIrqEnable && flags_q[CANES_BIT_TIMER];
  assign bufIrq = bufferIrqEnable && flags_q[CANES_BIT_BUF];
  assign generalIrq = generalErrorIrqEnable && (|flags_q[CANES_BIT_STUFF:CANES_BIT_ACK]);
  assign controllerIrq = timerIrq || bufIrq || generalIrq || otherIrq;

  // Error counters
  always_comb begin
    logic anyErr;
    anyErr = |err;
    tec_d = tec_q;
    rec_d = rec_q;
    if (anyErr) begin
      if (isTransmitter) begin
        tec_d = satAdd(tec_q, CANES_TX_ERR_STEP);
      end else begin
        rec_d = satAdd(rec_q, CANES_RX_ERR_STEP);
      end
    end else begin
      if (txFrameOk && tec_q != CANES_CNT_RESET) begin
        tec_d = tec_q - 8'h01;
      end
      if (rxFrameOk) begin
        // Above passive top the count snaps back into passive range
        if (rec_q > CANES_REC_PASSIVE_TOP) begin
          rec_d = CANES_REC_PASSIVE_TOP;
        end else if (rec_q != CANES_CNT_RESET) begin
          rec_d = rec_q - 8'h01;
        end
      end
    end
  end

  // Read data, one cycle after address
  always_comb begin
    case (sfrReq.addr)
      CANES_GIT_ADDR: rdData_d = {controllerIrq, 1'b0, flags_q};
      CANES_TEC_ADDR: rdData_d = tec_q;
      CANES_REC_ADDR: rdData_d = rec_q;
      default: rdData_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= CANES_GIT_RESET[5:0];
      timer_q <= CANES_TIMER_RESET;
      tec_q <= CANES_CNT_RESET;
      rec_q <= CANES_CNT_RESET;
      runLen_q <= 3'h0;
      lastBit_q <= 1'b1;
      crc_q <= CANES_CRC_RESET;
      rxCrc_q <= CANES_CRC_RESET;
      rdData_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
      timer_q <= timer_d;
      tec_q <= tec_d;
      rec_q <= rec_d;
      runLen_q <= runLen_d;
      lastBit_q <= lastBit_d;
      crc_q <= crc_d;
      rxCrc_q <= rxCrc_d;
      rdData_q <= rdData_d;
    end
  end

  assign sfrRdData = rdData_q;
  assign canTimer = timer_q;
  assign txErrorCount = tec_q;
  assign rxErrorCount = rec_q;

  sequence wrapSeen;
    timerTick && (timer_q == CANES_TIMER_MAX);
  endsequence

  timer_wrap_a: assert property (@(posedge clk) disable iff (rst)
    wrapSeen |=> flags_q[CANES_BIT_TIMER] && (timer_q == 16'h0000))
    else $error("timer wrap did not set flag");

  timer_irq_a: assert property (@(posedge clk) disable iff (rst)
    (flags_q[CANES_BIT_TIMER] && timerWrapIrqEnable) |-> controllerIrq)
    else $error("timer flag did not request interrupt");

  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    (rxBufferFull && gitWrite && !sfrReq.wrData[CANES_BIT_BUF]) |=> flags_q[CANES_BIT_BUF])
    else $error("buffer event lost to clear");

  sticky_flags_a: assert property (@(posedge clk) disable iff (rst)
    ($past(flags_q[CANES_BIT_STUFF]) && !$past(gitWrite)) |-> flags_q[CANES_BIT_STUFF])
    else $error("stuff flag dropped without clear");

  stuff_err_a: assert property (@(posedge clk) disable iff (rst)
    (bitValid && stuffed && !frameStart && runLen_q == CANES_STUFF_RUN && rxBit == lastBit_q)
    |=> flags_q[CANES_BIT_STUFF])
    else $error("sixth equal bit not flagged");

  ack_err_a: assert property (@(posedge clk) disable iff (rst)
    (bitValid && frameField == CANES_FLD_ACK_SLOT && rxBit) |=> flags_q[CANES_BIT_ACK])
    else $error("recessive ack slot not flagged");

  gen_mask_a: assert property (@(posedge clk) disable iff (rst)
    (!generalErrorIrqEnable && !timerIrq && !bufIrq && !otherIrq) |-> !controllerIrq)
    else $error("masked error reached summary");

  buf_irq_a: assert property (@(posedge clk) disable iff (rst)
    (bufferIrqEnable && flags_q[CANES_BIT_BUF]) |-> controllerIrq)
    else $error("buffer flag did not request interrupt");

  tec_step_a: assert property (@(posedge clk) disable iff (rst)
    ((|err) && isTransmitter && tec_q < 8'hF0) |=> tec_q == $past(tec_q) + 8'h08)
    else $error("transmit count did not step by eight");

  summary_read_a: assert property (@(posedge clk) disable iff (rst)
    (sfrReq.addr == CANES_GIT_ADDR) |=> sfrRdData[CANES_BIT_SUMMARY] == $past(controllerIrq))
    else $error("summary bit differs from request");

  sequence sofBit;
    bitValid && frameStart && frameField == CANES_FLD_FRAME;
  endsequence

  crc_start_a: assert property (@(posedge clk) disable iff (rst)
    sofBit |=> crc_q == crcStep(CANES_CRC_RESET, $past(rxBit)))
    else $error("crc not restarted at frame start");

  buf_set_a: assert property (@(posedge clk) disable iff (rst)
    rxBufferFull |=> flags_q[CANES_BIT_BUF])
    else $error("buffer full not flagged");

  crc_err_a: assert property (@(posedge clk) disable iff (rst)
    (bitValid && frameField == CANES_FLD_CRC_DELIM && rxCrc_q != crc_q) |=> flags_q[CANES_BIT_CRC])
    else $error("crc mismatch not flagged");

  form_err_a: assert property (@(posedge clk) disable iff (rst)
    (bitValid && !rxBit && (frameField == CANES_FLD_CRC_DELIM ||
      frameField == CANES_FLD_ACK_DELIM || frameField == CANES_FLD_EOF)) |=> flags_q[CANES_BIT_FORM])
    else $error("form violation not flagged");

  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    (gitWrite && !sfrReq.wrData[CANES_BIT_TIMER] && !timerWrap) |=> !flags_q[CANES_BIT_TIMER])
    else $error("timer flag survived clear");

  tec_readonly_a: assert property (@(posedge clk) disable iff (rst)
    (!(|err) && !txFrameOk) |=> tec_q == $past(tec_q))
    else $error("transmit count changed without event");

  rec_readonly_a: assert property (@(posedge clk) disable iff (rst)
    (!(|err) && !rxFrameOk) |=> rec_q == $past(rec_q))
    else $error("receive count changed without event");

  rec_step_a: assert property (@(posedge clk) disable iff (rst)
    ((|err) && !isTransmitter && rec_q < 8'hFF) |=> rec_q == $past(rec_q) + 8'h01)
    else $error("receive count did not step by one");

  irq_idle_a: assert property (@(posedge clk) disable iff (rst)
    (!timerIrq && !bufIrq && !generalIrq && !otherIrq) |-> !controllerIrq)
    else $error("summary raised with no source");
endmodule

//--- dv/canes_bus_node.sv
`timescale 1ns/1ps
module canes_bus_node (
  // Clock
  input wire logic clk,
  // Bit stream toward the receiver
  output logic bitValid,
  output logic rxBit,
  output logic frameStart,
  output canes_pkg::canes_field_type frameField
);
  import canes_pkg::*;
  logic lastBit;
  int run;
  initial begin
    bitValid = 1'b0;
    rxBit = 1'b1;
    frameStart = 1'b0;
    frameField = CANES_FLD_OTHER;
  end
  // Released bus reads recessive between bits
  task automatic sendBit(input logic b, input canes_field_type f, input logic sof);
    @(posedge clk);
    bitValid <= 1'b1;
    rxBit <= b;
    frameField <= f;
    frameStart <= sof;
    @(posedge clk);
    bitValid <= 1'b0;
    rxBit <= 1'b1;
    frameStart <= 1'b0;
    frameField <= CANES_FLD_OTHER;
  endtask
  // Stuff bit counts toward the next run, as on a real bus
  task automatic sendData(input logic b, input canes_field_type f, input logic sof);
    run = (sof || b !== lastBit) ? 1 : run + 1;
    lastBit = b;
    sendBit(b, f, sof);
    if (run == 5) begin
      lastBit = ~b;
      run = 1;
      sendBit(~b, f, 1'b0);
    end
  endtask
  task automatic sendFrame(input logic [7:0] d, input logic badCrc, input logic ackDom,
                           input logic delim);
    logic [14:0] crc;
    logic [8:0] body;
    logic nx;
    crc = 15'h0000;
    body = {1'b0, d};
    for (int i = 8; i >= 0; i--) begin
      nx = body[i] ^ crc[14];
      crc = {crc[13:0], 1'b0} ^ (nx ? CANES_CRC_POLY : 15'h0000);
    end
    for (int i = 8; i >= 0; i--) sendData(body[i], CANES_FLD_FRAME, i == 8);
    crc[0] = crc[0] ^ badCrc;
    for (int i = 14; i >= 0; i--) sendData(crc[i], CANES_FLD_CRC, 1'b0);
    sendBit(delim, CANES_FLD_CRC_DELIM, 1'b0);
    sendBit(~ackDom, CANES_FLD_ACK_SLOT, 1'b0);
    sendBit(1'b1, CANES_FLD_ACK_DELIM, 1'b0);
    repeat (7) sendBit(1'b1, CANES_FLD_EOF, 1'b0);
  endtask
endmodule

//--- dv/test_can_error_status_and_counters.sv
`timescale 1ns/1ps
module test_can_error_status_and_counters;
  import canes_pkg::*;
  logic clk, rst, timerWrapIrqEnable, generalErrorIrqEnable, bufferIrqEnable, otherIrq;
  logic timerTick, rxBufferFull, isTransmitter, txFrameOk, rxFrameOk;
  logic bitValid, rxBit, frameStart, destuffedValid, controllerIrq;
  logic [7:0] sfrRdData, txErrorCount, rxErrorCount, rd;
  logic [15:0] canTimer;
  canes_field_type frameField;
  canes_sfr_req_type sfrReq;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int nDestuffed = 0;
  int mark = 0;
  canes_error_status uut (.clk(clk), .rst(rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .timerWrapIrqEnable(timerWrapIrqEnable), .generalErrorIrqEnable(generalErrorIrqEnable),
    .bufferIrqEnable(bufferIrqEnable), .otherIrq(otherIrq), .timerTick(timerTick),
    .rxBufferFull(rxBufferFull), .isTransmitter(isTransmitter), .txFrameOk(txFrameOk),
    .rxFrameOk(rxFrameOk), .bitValid(bitValid), .rxBit(rxBit), .frameStart(frameStart),
    .frameField(frameField), .destuffedValid(destuffedValid), .controllerIrq(controllerIrq),
    .canTimer(canTimer), .txErrorCount(txErrorCount), .rxErrorCount(rxErrorCount));
  canes_bus_node node (.clk(clk), .bitValid(bitValid), .rxBit(rxBit),
    .frameStart(frameStart), .frameField(frameField));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Data bits seen past the destuffer
  always @(negedge clk) begin
    if (destuffedValid === 1'b1) nDestuffed++;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is about 66k cycles, dominated by the timer wrap
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task sfrWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrReq <= '{a, 1'b1, d};
    @(posedge clk);
    sfrReq.wrEn <= 1'b0;
  endtask
  task expectReg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfrReq <= '{a, 1'b0, 8'h00};
    @(posedge clk);
    @(negedge clk);
    check(sfrRdData, e, "sfr read");
  endtask
  task irqIs(input logic e);
    @(negedge clk);
    check(controllerIrq, e, "irq");
  endtask
  task frameOk(input logic tx);
    @(posedge clk);
    txFrameOk <= tx;
    rxFrameOk <= ~tx;
    @(posedge clk);
    txFrameOk <= 1'b0;
    rxFrameOk <= 1'b0;
  endtask
  task test_reset;
    expectReg(CANES_GIT_ADDR, 8'h00);
    sfrWrite(CANES_TEC_ADDR, 8'hFF);
    sfrWrite(CANES_REC_ADDR, 8'hFF);
    expectReg(CANES_TEC_ADDR, 8'h00);
    expectReg(CANES_REC_ADDR, 8'h00);
    expectReg(8'h9A, 8'h00);
    $display("test_reset done");
  endtask
  task test_frames;
    mark = nDestuffed;
    node.sendFrame(8'hA5, 1'b0, 1'b1, 1'b1);
    check(16'(nDestuffed - mark), 16'h0018, "destuffed bits");
    expectReg(CANES_GIT_ADDR, 8'h00);
    node.sendFrame(8'hA5, 1'b1, 1'b1, 1'b1);
    expectReg(CANES_GIT_ADDR, 8'h04);
    irqIs(1'b0);
    @(posedge clk) generalErrorIrqEnable <= 1'b1;
    irqIs(1'b1);
    expectReg(CANES_GIT_ADDR, 8'h84);
    sfrWrite(CANES_GIT_ADDR, 8'hFB);
    expectReg(CANES_GIT_ADDR, 8'h00);
    node.sendFrame(8'hA5, 1'b0, 1'b0, 1'b1);
    expectReg(CANES_GIT_ADDR, 8'h81);
    sfrWrite(CANES_GIT_ADDR, 8'h00);
    node.sendFrame(8'hA5, 1'b0, 1'b1, 1'b0);
    expectReg(CANES_GIT_ADDR, 8'h82);
    expectReg(CANES_REC_ADDR, 8'h03);
    frameOk(1'b0);
    expectReg(CANES_REC_ADDR, 8'h02);
    @(posedge clk) isTransmitter <= 1'b1;
    node.sendFrame(8'hA5, 1'b0, 1'b0, 1'b1);
    expectReg(CANES_TEC_ADDR, 8'h08);
    frameOk(1'b1);
    isTransmitter <= 1'b0;
    expectReg(CANES_TEC_ADDR, 8'h07);
    check(txErrorCount, 8'h07, "tec port");
    sfrWrite(CANES_GIT_ADDR, 8'h00);
    $display("test_frames done");
  endtask
  task test_stuff;
    mark = nDestuffed;
    for (int i = 0; i < 6; i++) node.sendBit(1'b0, CANES_FLD_FRAME, i == 0);
    check(16'(nDestuffed - mark), 16'h0005, "destuffed bits");
    expectReg(CANES_GIT_ADDR, 8'h88);
    expectReg(CANES_REC_ADDR, 8'h03);
    check(rxErrorCount, 8'h03, "rec port");
    sfrWrite(CANES_GIT_ADDR, 8'h00);
    generalErrorIrqEnable <= 1'b0;
    $display("test_stuff done");
  endtask
  task test_buf;
    @(posedge clk);
    rxBufferFull <= 1'b1;
    @(posedge clk);
    rxBufferFull <= 1'b0;
    irqIs(1'b0);
    @(posedge clk) bufferIrqEnable <= 1'b1;
    irqIs(1'b1);
    // Set and clear on the same edge
    @(posedge clk);
    sfrReq <= '{CANES_GIT_ADDR, 1'b1, 8'h00};
    rxBufferFull <= 1'b1;
    @(posedge clk);
    sfrReq.wrEn <= 1'b0;
    rxBufferFull <= 1'b0;
    expectReg(CANES_GIT_ADDR, 8'h90);
    sfrWrite(CANES_GIT_ADDR, 8'hEF);
    irqIs(1'b0);
    @(posedge clk) otherIrq <= 1'b1;
    irqIs(1'b1);
    @(posedge clk) otherIrq <= 1'b0;
    $display("test_buf done");
  endtask
  task test_timer;
    @(posedge clk);
    timerTick <= 1'b1;
    repeat (65535) @(posedge clk);
    timerTick <= 1'b0;
    @(negedge clk);
    check(canTimer, 16'hFFFF, "timer");
    expectReg(CANES_GIT_ADDR, 8'h00);
    @(posedge clk);
    timerTick <= 1'b1;
    @(posedge clk);
    timerTick <= 1'b0;
    @(negedge clk);
    check(canTimer, 16'h0000, "timer");
    expectReg(CANES_GIT_ADDR, 8'h20);
    irqIs(1'b0);
    @(posedge clk) timerWrapIrqEnable <= 1'b1;
    irqIs(1'b1);
    sfrWrite(CANES_GIT_ADDR, 8'hDF);
    irqIs(1'b0);
    $display("test_timer done");
  endtask
  initial begin
    rst = 1'b1;
    sfrReq = '0;
    {timerWrapIrqEnable, generalErrorIrqEnable, bufferIrqEnable, otherIrq} = 4'h0;
    {timerTick, rxBufferFull, isTransmitter, txFrameOk, rxFrameOk} = 5'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_frames();
    test_stuff();
    test_buf();
    test_timer();
    wrap_up();
  end
endmodule
